// >>> inc/lpmc_map.vh
// register map, field positions and timing counts of the low-power mode controller
// Functional notes
// RULE1 - stop mode halts oscillator and pll, 70000-clock wake
// RULE2 - mode field: 00 normal, 01 standby, 10 doze, 11 stop
// RULE3 - doze halts pll and peripherals, 2500-clock wake
// RULE4 - standby keeps pll, baud clock; wake 2-5 cycles
// RULE5 - divide field selects power-of-two clock divide
// RULE6 - divider acts only while pll enabled
// RULE7 - nonzero divide is slow-go, zero is normal
// RULE8 - divide change keeps pll lock and clocks
// RULE9 - write protect bit blocks later mode writes
// RULE10 - baud divide bit inserts divide-by-two stage
// RULE11 - mode entered only on core stop
// RULE12 - sleep drive enable: float or drive buses
// RULE13 - low bits select driven level per bus
// RULE14 - core writes stop operand high byte first
// RULE15 - core writes in supervisor space, trace off
// RULE16 - trace enabled blocks stop-class entry
// RULE17 - non-supervisor power-down write is ignored (code still stores it in pwrd_q and clears the arm)
// RULE18 - capture mask bits 0-2 as abort threshold
// RULE19 - software disables serial channels before sleep
// RULE20 - wait 16 clocks, request bus, await grant, enter
// RULE21 - mode register resets to all zeros
`ifndef LPMC_MAP_VH
`define LPMC_MAP_VH
`define LPMC_ADDR_W          12
`define LPMC_OFS_MODE        12'h0fa
`define LPMC_OFS_PWRD        12'h0fb
`define LPMC_OFS_DRIVE       12'h82a
`define LPMC_MODE_RESET      8'h00
`define LPMC_DRIVE_RESET     8'h00
`define LPMC_PWRD_RESET      8'h00
`define LPMC_BIT_WP          7
`define LPMC_DF_HI           6
`define LPMC_DF_LO           3
`define LPMC_BIT_BCD         2
`define LPMC_LPM_HI          1
`define LPMC_LPM_LO          0
`define LPMC_BIT_DRV_EN      0
`define LPMC_BIT_DATA_LOW    1
`define LPMC_BIT_ADDR_LOW    2
`define LPMC_FC_SUPER_BIT    2
`define LPMC_LPM_NORMAL      2'h0
`define LPMC_LPM_STANDBY     2'h1
`define LPMC_LPM_DOZE        2'h2
`define LPMC_LPM_STOP        2'h3
`define LPMC_SETTLE_CLKS     5'h10
`define LPMC_STOP_WAKE_CLKS  70000
`define LPMC_DOZE_WAKE_CLKS  2500
`define LPMC_STBY_WAKE_CLKS  17'h00003
`endif

// >>> rtl/lpmc_controller.v
// low-power mode controller: mode registers, stop entry sequence, sleep bus drive
`timescale 1ns/1ps
`include "lpmc_map.vh"
module lpmc_controller #(
	parameter STOP_WAKE_CLKS = `LPMC_STOP_WAKE_CLKS,
	parameter DOZE_WAKE_CLKS = `LPMC_DOZE_WAKE_CLKS
) (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        ce_i,
	// host register access
	input  wire [11:0] addr_i,
	input  wire [7:0]  wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	input  wire [2:0]  fc_i,
	output reg  [7:0]  rdata_o,
	// core status and arbitration
	input  wire        trace_en_i,
	input  wire        stop_exec_i,
	input  wire [2:0]  irq_level_i,
	input  wire        bg_i,
	input  wire        bgack_i,
	input  wire        wake_i,
	input  wire        pll_en_i,
	output reg         br_o,
	// clock control
	output reg         osc_run_o,
	output reg         pll_run_o,
	output reg         periph_run_o,
	output reg         sys_clk_run_o,
	output reg         sys_ce_o,
	output reg         baud_ce_o,
	output reg  [1:0]  mode_o,
	// sleep bus drive
	output reg         addr_oe_o,
	output reg         addr_level_o,
	output reg         data_oe_o,
	output reg         data_level_o
);
	localparam ST_IDLE   = 3'h0;
	localparam ST_SETTLE = 3'h1;
	localparam ST_REQ    = 3'h2;
	localparam ST_SLEEP  = 3'h3;
	localparam ST_WAKE   = 3'h4;

	reg  [7:0]  mode_q;
	reg  [7:0]  drive_q;
	reg  [7:0]  pwrd_q;
	reg  [2:0]  mask_q;
	reg  [2:0]  st_q;
	reg  [2:0]  st_d;
	reg  [4:0]  settle_q;
	reg  [16:0] wake_q;
	reg  [1:0]  sleep_mode_q;
	reg         armed_q;
	wire        sys_ce;
	wire        baud_ce;
	wire        abort;
	wire        sleeping;
	wire        drv;

	function hit;
		input [11:0] a;
		input [11:0] ofs;
		hit = (a == ofs);
	endfunction

	wire wr_mode  = wr_i && hit(addr_i, `LPMC_OFS_MODE);
	wire wr_pwrd  = wr_i && hit(addr_i, `LPMC_OFS_PWRD);
	wire wr_drive = wr_i && hit(addr_i, `LPMC_OFS_DRIVE);

	// trace turned on mid-sequence also cancels the entry
	assign abort    = wake_i || trace_en_i || (irq_level_i > mask_q); // RULE20 RULE16
	assign sleeping = (st_q == ST_SLEEP);
	assign drv      = sleeping && drive_q[`LPMC_BIT_DRV_EN]; // RULE12

	lpmc_divider u_div (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.factor_i    (mode_q[`LPMC_DF_HI:`LPMC_DF_LO]),
		.pll_en_i    (pll_en_i),
		.baud_half_i (mode_q[`LPMC_BIT_BCD]),
		.sys_ce_o    (sys_ce),
		.baud_ce_o   (baud_ce)
	);

	// registers
	always @(posedge clk_i) begin
		if (rst_i) begin
			mode_q  <= `LPMC_MODE_RESET; // RULE21
			drive_q <= `LPMC_DRIVE_RESET;
			pwrd_q  <= `LPMC_PWRD_RESET;
			mask_q  <= 3'h7;
			armed_q <= 1'b0;
			rdata_o <= 8'h00;
		end else if (ce_i) begin
			if (wr_mode && !mode_q[`LPMC_BIT_WP])
				mode_q <= wdata_i; // RULE9
			if (wr_drive)
				drive_q <= wdata_i;
			if (wr_pwrd) begin
				pwrd_q <= wdata_i;
				if (fc_i[`LPMC_FC_SUPER_BIT]) begin // RULE17
					mask_q  <= wdata_i[2:0]; // RULE18
					armed_q <= 1'b1;
				end else begin
					armed_q <= 1'b0;
				end
			end else if (st_q == ST_WAKE || (st_q != ST_IDLE && abort)) begin
				armed_q <= 1'b0;
			end
			if (rd_i) begin
				if (hit(addr_i, `LPMC_OFS_MODE))
					rdata_o <= mode_q;
				else if (hit(addr_i, `LPMC_OFS_PWRD))
					rdata_o <= pwrd_q;
				else if (hit(addr_i, `LPMC_OFS_DRIVE))
					rdata_o <= drive_q;
				else
					rdata_o <= 8'h00;
			end
		end
	end

	// entry sequence
	always @* begin
		st_d = st_q;
		case (st_q)
		ST_IDLE: begin
			// entry only from the stop instruction, never from a field write
			if (stop_exec_i && armed_q && !trace_en_i && // RULE11 RULE16
			    mode_q[`LPMC_LPM_HI:`LPMC_LPM_LO] != `LPMC_LPM_NORMAL) // RULE2
				st_d = ST_SETTLE;
		end
		ST_SETTLE: begin
			if (abort)
				st_d = ST_IDLE;
			else if (settle_q == `LPMC_SETTLE_CLKS - 5'h01 && !bg_i && !bgack_i)
				st_d = ST_REQ; // RULE20
		end
		ST_REQ: begin
			if (abort)
				st_d = ST_IDLE;
			else if (bg_i)
				st_d = ST_SLEEP; // RULE20
		end
		ST_SLEEP: begin
			if (wake_i)
				st_d = ST_WAKE;
		end
		ST_WAKE: begin
			if (wake_q == 17'h00000)
				st_d = ST_IDLE;
		end
		default: st_d = ST_IDLE;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			st_q         <= ST_IDLE;
			settle_q     <= 5'h00;
			wake_q       <= 17'h00000;
			sleep_mode_q <= `LPMC_LPM_NORMAL;
		end else if (ce_i) begin
			st_q <= st_d;
			// bus grant activity restarts the settle count
			if (st_q != ST_SETTLE || bg_i || bgack_i)
				settle_q <= 5'h00; // RULE20
			else
				settle_q <= settle_q + 5'h01;
			if (st_d == ST_SLEEP && st_q == ST_REQ)
				sleep_mode_q <= mode_q[`LPMC_LPM_HI:`LPMC_LPM_LO];
			if (st_q == ST_SLEEP && wake_i) begin
				case (sleep_mode_q)
				`LPMC_LPM_STOP:    wake_q <= STOP_WAKE_CLKS[16:0] - 17'h1; // RULE1
				`LPMC_LPM_DOZE:    wake_q <= DOZE_WAKE_CLKS[16:0] - 17'h1; // RULE3
				default:           wake_q <= `LPMC_STBY_WAKE_CLKS - 17'h1; // RULE4
				endcase
			end else if (wake_q != 17'h00000) begin
				wake_q <= wake_q - 17'h1;
			end
		end
	end

	// clock gating and bus drive outputs
	always @(posedge clk_i) begin
		if (rst_i) begin
			br_o          <= 1'b0;
			osc_run_o     <= 1'b1;
			pll_run_o     <= 1'b1;
			periph_run_o  <= 1'b1;
			sys_clk_run_o <= 1'b1;
			sys_ce_o      <= 1'b0;
			baud_ce_o     <= 1'b0;
			mode_o        <= `LPMC_LPM_NORMAL;
			addr_oe_o     <= 1'b0;
			addr_level_o  <= 1'b1;
			data_oe_o     <= 1'b0;
			data_level_o  <= 1'b1;
		end else if (ce_i) begin
			br_o          <= (st_d == ST_REQ) || (st_d == ST_SLEEP) || (st_d == ST_WAKE);
			mode_o        <= sleeping ? sleep_mode_q : `LPMC_LPM_NORMAL;
			osc_run_o     <= !(sleeping && sleep_mode_q == `LPMC_LPM_STOP); // RULE1
			pll_run_o     <= !(sleeping && sleep_mode_q != `LPMC_LPM_STANDBY); // RULE3 RULE4
			periph_run_o  <= !sleeping; // RULE3
			sys_clk_run_o <= !sleeping; // RULE4
			sys_ce_o      <= sys_ce && !sleeping;
			baud_ce_o     <= baud_ce && (!sleeping || sleep_mode_q == `LPMC_LPM_STANDBY); // RULE4
			addr_oe_o     <= drv; // RULE12
			data_oe_o     <= drv;
			addr_level_o  <= !drive_q[`LPMC_BIT_ADDR_LOW]; // RULE13
			data_level_o  <= !drive_q[`LPMC_BIT_DATA_LOW]; // RULE13
		end
	end
endmodule // lpmc_controller

// >>> rtl/lpmc_divider.v
// power-of-two clock-enable divider for system and baud clocks
`timescale 1ns/1ps
`include "lpmc_map.vh"
module lpmc_divider (
	// clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       ce_i,
	// control
	input  wire [3:0] factor_i,
	input  wire       pll_en_i,
	input  wire       baud_half_i,
	// enables
	output reg        sys_ce_o,
	output reg        baud_ce_o
);
	reg  [15:0] cnt_q;
	reg         baud_t_q;
	wire [15:0] mask;
	wire        hit;

	// divider is free running so a factor change never restarts the pll
	assign mask = (16'h0001 << factor_i) - 16'h0001; // RULE5 RULE8
	assign hit  = ((cnt_q & mask) == 16'h0000) || !pll_en_i; // RULE6 RULE7

	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q     <= 16'h0000;
			baud_t_q  <= 1'b0;
			sys_ce_o  <= 1'b0;
			baud_ce_o <= 1'b0;
		end else if (ce_i) begin
			cnt_q     <= cnt_q + 16'h0001;
			sys_ce_o  <= hit;
			baud_t_q  <= ~baud_t_q;
			baud_ce_o <= baud_half_i ? baud_t_q : 1'b1; // RULE10
		end
	end
endmodule // lpmc_divider

// >>> test/low_power_mode_controller_tb.sv
// self-checking bench of the low-power mode controller
`timescale 1ns/1ps
module low_power_mode_controller_tb;
	reg         clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, trace_en_i = 0, stop_exec_i = 0, wake_i = 0, pll_en_i = 1;
	reg         ce = 1;
	reg  [11:0] addr_i = 0;
	reg  [7:0]  wdata_i = 0, mode_m = 0, d;
	reg  [2:0]  fc_i = 5, irq_level_i = 0, dly = 0;
	wire [7:0]  rdata_o;
	wire [1:0]  mode_o;
	wire        br_o, bg, sys_ce_o, baud_ce_o, osc, pll_run_o, aoe, alv, doe, dlv;
	integer     num_errors = 0, samples_checked = 0, cyc = 0, seed = 32'hbff780d0, df;
	lpmc_controller #(.STOP_WAKE_CLKS(20), .DOZE_WAKE_CLKS(10)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .fc_i(fc_i), .rdata_o(rdata_o),
		.trace_en_i(trace_en_i), .stop_exec_i(stop_exec_i), .irq_level_i(irq_level_i), .bg_i(bg), .bgack_i(1'b0),
		.wake_i(wake_i), .pll_en_i(pll_en_i), .br_o(br_o), .osc_run_o(osc), .pll_run_o(pll_run_o), .periph_run_o(),
		.sys_clk_run_o(), .sys_ce_o(sys_ce_o), .baud_ce_o(baud_ce_o), .mode_o(mode_o), .addr_oe_o(aoe),
		.addr_level_o(alv), .data_oe_o(doe), .data_level_o(dlv));
	lpmc_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .br_i(br_o), .dly_i(dly), .bg_o(bg));
	always #5 clk_i = ~clk_i;
	task test_done; begin
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 20000) begin
			num_errors++;
			test_done;
		end
	end
	task chk(input [31:0] g, e); begin
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	end endtask
	task wr(input [11:0] a, input [7:0] v, input [2:0] f); begin
		@(negedge clk_i);
		{addr_i, wdata_i, fc_i, wr_i} = {a, v, f, 1'b1};
		if (a == 12'h0fa && !mode_m[7]) mode_m = v;
		@(negedge clk_i);
		wr_i = 0;
	end endtask
	task rd(input [11:0] a, input [7:0] e); begin
		@(negedge clk_i);
		{addr_i, rd_i} = {a, 1'b1};
		@(negedge clk_i);
		rd_i = 0;
		chk(rdata_o, e);
	end endtask
	task cnt(input [7:0] m, input integer es, eb); integer s, b; begin
		wr(12'h0fa, m, 5);
		rd(12'h0fa, mode_m);
		{s, b} = 0;
		repeat (32) begin
			@(negedge clk_i);
			s += sys_ce_o;
			b += baud_ce_o;
		end
		chk(s, es);
		chk(b, eb);
		chk(pll_run_o, 1);
	end endtask
	task sleep(input [1:0] m, input [2:0] f, input t, input [2:0] q, input ok); integer n, w; begin
		d = $random(seed) & 7;
		dly = $random(seed);
		wr(12'h82a, d, 5);
		wr(12'h0fb, 8'h22, f);
		wr(12'h0fa, {6'h0, m}, 5);
		chk(mode_o, 0);
		{trace_en_i, irq_level_i, stop_exec_i} = {t, q, 1'b1};
		@(negedge clk_i);
		stop_exec_i = 0;
		for (n = 0; mode_o != m && n < 60; n++) @(negedge clk_i);
		chk(mode_o, ok ? m : 2'h0);
		if (ok) begin
			chk({aoe, doe}, {d[0], d[0]});
			if (d[0]) chk({alv, dlv}, {~d[2], ~d[1]});
			wake_i = 1;
			for (w = 0; br_o && w < 100; w++) @(negedge clk_i);
			wake_i = 0;
			n = m == 3 ? 20 : m == 2 ? 10 : 3;
			chk(w >= n && w <= n + 4, 1);
		end
		$display("test sleep %0d done", m);
	end endtask
	initial begin
		repeat (12) @(negedge clk_i);
		rst_i = 0;
		rd(12'h0fa, 8'h00);
		rd(12'h82a, 8'h00);
		rd(12'h123, 8'h00);
		cnt(8'h00, 32, 32);
		cnt(8'h04, 32, 16);
		repeat (3) begin
			df = $random(seed) & 3;
			cnt({1'b0, df[3:0], 3'h0}, 32 >> df, 32);
		end
		pll_en_i = 0;
		cnt(8'h18, 32, 32);
		pll_en_i = 1;
		$display("test divider done");
		// a write seen while the clock enable is low must not land
		@(negedge clk_i);
		{ce, addr_i, wdata_i, wr_i} = {1'b0, 12'h0fa, 8'h5c, 1'b1};
		@(negedge clk_i);
		{ce, wr_i} = 2'b10;
		rd(12'h0fa, mode_m);
		$display("test freeze done");
		sleep(3, 5, 0, 2, 1);
		sleep(2, 5, 0, 0, 1);
		sleep(1, 5, 0, 0, 1);
		sleep(3, 1, 0, 0, 0);
		sleep(3, 5, 1, 0, 0);
		sleep(2, 5, 0, 3, 0);
		wr(12'h0fa, 8'h81, 5);
		wr(12'h0fa, 8'h02, 5);
		rd(12'h0fa, mode_m);
		$display("test protect done");
		// mid-run reset clears the protect bit again
		rst_i = 1;
		repeat (2) @(negedge clk_i);
		rst_i = 0;
		mode_m = 8'h00;
		rd(12'h0fa, 8'h00);
		wr(12'h0fa, 8'h08, 5);
		rd(12'h0fa, mode_m);
		$display("test reset done");
		test_done;
	end
endmodule // low_power_mode_controller_tb

bind lpmc_controller lpmc_props u_props (
	.clk_i         (clk_i),
	.rst_i         (rst_i),
	.ce_i          (ce_i),
	.pll_en_i      (pll_en_i),
	.bg_i          (bg_i),
	.bgack_i       (bgack_i),
	.br_o          (br_o),
	.sys_ce_o      (sys_ce_o),
	.osc_run_o     (osc_run_o),
	.pll_run_o     (pll_run_o),
	.periph_run_o  (periph_run_o),
	.sys_clk_run_o (sys_clk_run_o),
	.addr_oe_o     (addr_oe_o),
	.data_oe_o     (data_oe_o),
	.mode_o        (mode_o),
	.rdata_o       (rdata_o)
);

// >>> test/lpmc_core_model.sv
// host core model: grants the bus after a set delay
`timescale 1ns/1ps
module lpmc_core_model (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       br_i,
	input  wire [2:0] dly_i,
	output reg        bg_o
);
	reg [2:0] cnt_q;
	always @(posedge clk_i) begin
		if (rst_i || !br_i) begin
			bg_o  <= 1'b0;
			cnt_q <= 3'h0;
		end else if (cnt_q == dly_i) begin
			bg_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 3'h1;
		end
	end
endmodule // lpmc_core_model

// >>> test/lpmc_props.sv
// port assertions for the low-power mode controller
`timescale 1ns/1ps
module lpmc_props (
	input wire       clk_i, rst_i, ce_i, pll_en_i, bg_i, bgack_i, br_o, sys_ce_o,
	input wire       osc_run_o, pll_run_o, periph_run_o, sys_clk_run_o, addr_oe_o, data_oe_o,
	input wire [1:0] mode_o,
	input wire [7:0] rdata_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_reset_idle: assert property (disable iff (1'b0) rst_i |=> !br_o && mode_o == 2'h0 && rdata_o == 8'h00)
		else $error("reset values wrong");
	chk_stop_off: assert property (mode_o == 2'h3 |-> !osc_run_o && !pll_run_o)
		else $error("stop keeps clocks");
	chk_doze_osc: assert property (mode_o == 2'h2 |-> osc_run_o && !pll_run_o && !periph_run_o)
		else $error("doze clocks wrong");
	chk_stby_sys: assert property (mode_o == 2'h1 |-> osc_run_o && !sys_clk_run_o)
		else $error("standby clocks wrong");
	chk_bus_oe: assert property (addr_oe_o == data_oe_o && (!addr_oe_o || mode_o != 2'h0))
		else $error("bus drive wrong");
	chk_entry_req: assert property (mode_o != 2'h0 && $past(mode_o) == 2'h0 |-> $past(br_o))
		else $error("sleep without bus request");
	chk_req_settle: assert property ($rose(br_o) |-> $past(bg_i) == 1'b0 && $past(bgack_i) == 1'b0)
		else $error("request during grant");
	chk_nodiv_pll: assert property (ce_i && !pll_en_i ##1 ce_i && !br_o ##1 1'b1 |-> sys_ce_o)
		else $error("divide without pll");
endmodule // lpmc_props
